// ### logic/selftest_consts.vh
`ifndef SELFTEST_CONSTS_VH
`define SELFTEST_CONSTS_VH

// register indices, byte address is four times the index
`define IDX_CONTROL       16'h40a0
`define IDX_GEN_LENGTH    16'h40a1
`define IDX_GEN_BURST     16'h40a2
`define IDX_RX_GOOD_HI    16'h40a3
`define IDX_RX_GOOD_LO    16'h40a4
`define IDX_RX_OS_HI      16'h40a5
`define IDX_RX_OS_LO      16'h40a6
`define IDX_RX_US_HI      16'h40a7
`define IDX_RX_US_LO      16'h40a8
`define IDX_RX_CRC_ERR    16'h40a9
`define IDX_RX_OS_CRC_ERR 16'h40aa
`define IDX_RX_FRAGMENT   16'h40ab
`define IDX_RX_NO_SFD     16'h40ac
`define IDX_TX_GOOD_HI    16'h40ad
`define IDX_TX_GOOD_LO    16'h40ae
`define IDX_TX_OS_HI      16'h40af
`define IDX_TX_OS_LO      16'h40b0
`define IDX_IRQ_STATUS    16'h4100
`define IDX_IRQ_CLEAR     16'h4101
`define IDX_IRQ_ENABLE    16'h4102

// control register fields
`define BIT_CHECKER_EN    15
`define BIT_GEN_EN        12

// reset values
`define RST_GEN_LENGTH    16'h0040
`define RST_GEN_BURST     16'h0000

// frame length classes, bytes
`define LEN_MIN           16'd64
`define LEN_MAX           16'd1518

// interrupt status bits
`define IRQ_BURST_DONE    0
`define IRQ_SATURATED     1
`define IRQ_WIDTH         2

`endif

// ### logic/sat_counter.v
`timescale 1ns/1ps
`default_nettype none

module sat_counter #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire inc,
    input wire clr_all,
    input wire clr_low,
    // state
    output reg [WIDTH-1:0] value,
    output wire saturated
);

localparam HALF = WIDTH / 2;

// an increment at the top value is dropped and flagged
assign saturated = inc & (&value) & ~clr_all & ~clr_low;

// clearing read wins over nothing: a same-cycle increment is kept
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        value <= {WIDTH{1'b0}};
    else if (clr_all)
        value <= {{(WIDTH-1){1'b0}}, inc};
    else if (clr_low)
        value <= {value[WIDTH-1:HALF], {(HALF-1){1'b0}}, inc};
    else if (inc && !(&value))
        value <= value + 1'b1;
end

endmodule // sat_counter

`default_nettype wire

// ### logic/phy_frame_selftest_counters.v
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "selftest_consts.vh"

module phy_frame_selftest_counters (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [17:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // receive checker results
    input wire rx_frame_done,
    input wire [15:0] rx_frame_len,
    input wire rx_crc_ok,
    input wire rx_sfd_missing,
    // transmit checker results
    input wire tx_frame_done,
    input wire [15:0] tx_frame_len,
    input wire tx_crc_ok,
    // frame generator datapath
    output reg gen_frame_req,
    output reg [15:0] gen_frame_length,
    input wire gen_frame_sent,
    output wire gen_busy,
    // enables to the rest of the self test
    output wire checker_enable,
    output wire gen_enable,
    // interrupt
    output wire irq
);

localparam G_IDLE = 1'b0;
localparam G_WAIT = 1'b1;

// length class: 0 under, 1 normal, 2 over
function [1:0] len_class;
    input [15:0] len;
    begin
        if (len < `LEN_MIN)
            len_class = 2'd0;
        else if (len > `LEN_MAX)
            len_class = 2'd2;
        else
            len_class = 2'd1;
    end
endfunction

reg pready_q;
reg [15:0] control;
reg [15:0] gen_burst_field;
reg [`IRQ_WIDTH-1:0] irq_status;
reg [`IRQ_WIDTH-1:0] irq_enable;
reg gen_state;
reg [15:0] gen_sent;
wire [15:0] cnt_rd [0:13];
wire [3:0] cnt_sel;
reg [31:0] next_prdata;
reg next_slverr;

wire [15:0] idx;
wire aligned;
wire read_cap;
wire write_done;
wire [1:0] rx_cls;
wire [1:0] tx_cls;
wire rx_ev;
wire tx_ev;
wire [4:0] wide_inc;
wire [3:0] narrow_inc;
wire [4:0] rd_hi;
wire [4:0] rd_lo;
wire [3:0] rd_narrow;
wire [4:0] wide_sat;
wire [3:0] narrow_sat;
wire [31:0] wide_val [0:4];
wire [15:0] narrow_val [0:3];
wire burst_end;
wire sw_ctrl_write;

// address decode
assign idx = paddr[17:2];
assign aligned = (paddr[1:0] == 2'b00);
// counter slot 0..13, wraps from 0x...b0 to 13
assign cnt_sel = idx[3:0] - 4'h3;

// one wait state: capture in first access cycle, complete in second
assign read_cap = psel & penable & ~pwrite & ~pready_q;
assign write_done = psel & penable & pwrite & pready_q;
assign pready = pready_q;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        pready_q <= 1'b0;
    else
        pready_q <= psel & penable & ~pready_q;
end

assign checker_enable = control[`BIT_CHECKER_EN];
assign gen_enable = control[`BIT_GEN_EN];
assign gen_busy = (gen_state == G_WAIT);

// checker events, counted only while the checker is on
assign rx_ev = rx_frame_done & checker_enable;
assign tx_ev = tx_frame_done & checker_enable;
assign rx_cls = len_class(rx_frame_len);
assign tx_cls = len_class(tx_frame_len);

// wide counter increments
assign wide_inc[0] = rx_ev & rx_crc_ok & (rx_cls == 2'd1);
assign wide_inc[1] = rx_ev & rx_crc_ok & (rx_cls == 2'd2);
assign wide_inc[2] = rx_ev & rx_crc_ok & (rx_cls == 2'd0);
assign wide_inc[3] = tx_ev & tx_crc_ok & (tx_cls == 2'd1);
assign wide_inc[4] = tx_ev & tx_crc_ok & (tx_cls == 2'd2);

// narrow counter increments
assign narrow_inc[0] = rx_ev & ~rx_crc_ok & (rx_cls == 2'd1);
assign narrow_inc[1] = rx_ev & ~rx_crc_ok & (rx_cls == 2'd2);
assign narrow_inc[2] = rx_ev & (rx_cls == 2'd0);
assign narrow_inc[3] = rx_ev & rx_sfd_missing;

// wide counters with upper/lower read-clear and snapshot
genvar gi;
generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_wide
        // slot of the upper half, counted from the first counter
        localparam integer SLOT = (gi < 3) ? 2 * gi : 2 * gi + 4;
        reg [15:0] snap;
        reg valid;

        assign rd_hi[gi] = read_cap & aligned
            & (idx == `IDX_RX_GOOD_HI + SLOT[15:0]);
        assign rd_lo[gi] = read_cap & aligned
            & (idx == `IDX_RX_GOOD_HI + SLOT[15:0] + 16'h0001);
        assign cnt_rd[SLOT] = wide_val[gi][31:16];
        assign cnt_rd[SLOT + 1] = valid ? snap : wide_val[gi][15:0];

        // upper read clears all, keeping lower in snapshot
        sat_counter #(
            .WIDTH(32)
        ) u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .inc(wide_inc[gi]),
            .clr_all(rd_hi[gi]),
            .clr_low(rd_lo[gi] & ~valid),
            .value(wide_val[gi]),
            .saturated(wide_sat[gi])
        );

        // lower half held until its own read
        always @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                snap <= 16'h0000;
                valid <= 1'b0;
            end
            else if (rd_hi[gi])
            begin
                snap <= wide_val[gi][15:0];
                valid <= 1'b1;
            end
            else if (rd_lo[gi])
                valid <= 1'b0;
        end
    end

    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_narrow
        localparam integer SLOT = gi + 6;

        assign rd_narrow[gi] = read_cap & aligned
            & (idx == `IDX_RX_GOOD_HI + SLOT[15:0]);
        assign cnt_rd[SLOT] = narrow_val[gi];

        sat_counter #(
            .WIDTH(16)
        ) u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .inc(narrow_inc[gi]),
            .clr_all(rd_narrow[gi]),
            .clr_low(1'b0),
            .value(narrow_val[gi]),
            .saturated(narrow_sat[gi])
        );
    end
endgenerate

// read data mux, counters only readable
always @*
begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    if (!aligned)
        next_slverr = 1'b1;
    else if (idx == `IDX_CONTROL)
        next_prdata = {16'h0000, control};
    else if (idx == `IDX_GEN_LENGTH)
        next_prdata = {16'h0000, gen_frame_length};
    else if (idx == `IDX_GEN_BURST)
        next_prdata = {16'h0000, gen_burst_field};
    else if (idx >= `IDX_RX_GOOD_HI && idx <= `IDX_TX_OS_LO)
        next_prdata = {16'h0000, cnt_rd[cnt_sel]};
    else if (idx == `IDX_IRQ_STATUS)
        next_prdata = {{(32-`IRQ_WIDTH){1'b0}}, irq_status};
    else if (idx == `IDX_IRQ_CLEAR)
        next_prdata = 32'h0000_0000;
    else if (idx == `IDX_IRQ_ENABLE)
        next_prdata = {{(32-`IRQ_WIDTH){1'b0}}, irq_enable};
    else
        next_slverr = 1'b1;
end

// read data and error, loaded in the first access cycle
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
    end
    else if (psel && penable && !pready_q)
    begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_slverr;
    end
end

// writable settings; counters ignore writes
assign sw_ctrl_write = write_done & aligned & (idx == `IDX_CONTROL);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        gen_frame_length <= `RST_GEN_LENGTH;
        gen_burst_field <= `RST_GEN_BURST;
        irq_enable <= {`IRQ_WIDTH{1'b0}};
    end
    else if (write_done && aligned)
    begin
        if (idx == `IDX_GEN_LENGTH)
            gen_frame_length <= pwdata[15:0];
        else if (idx == `IDX_GEN_BURST)
            gen_burst_field <= pwdata[15:0];
        else if (idx == `IDX_IRQ_ENABLE)
            irq_enable <= pwdata[`IRQ_WIDTH-1:0];
    end
end

// control: software write wins over generator self-clear
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        control <= 16'h0000;
    else if (sw_ctrl_write)
        control <= pwdata[15:0];
    else if (burst_end)
        control[`BIT_GEN_EN] <= 1'b0;
end

// generator sequencing of frame requests
assign burst_end = (gen_state == G_WAIT) & gen_frame_sent
    & (gen_burst_field != 16'h0000)
    & (gen_sent + 16'h0001 >= gen_burst_field);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        gen_state <= G_IDLE;
        gen_sent <= 16'h0000;
        gen_frame_req <= 1'b0;
    end
    else
    begin
        gen_frame_req <= 1'b0;
        case (gen_state)
            G_IDLE:
            begin
                gen_sent <= 16'h0000;
                if (gen_enable)
                begin
                    gen_frame_req <= 1'b1;
                    gen_state <= G_WAIT;
                end
            end
            G_WAIT:
            begin
                if (gen_frame_sent)
                begin
                    gen_sent <= gen_sent + 16'h0001;
                    if (burst_end || !gen_enable)
                        gen_state <= G_IDLE;
                    else
                        gen_frame_req <= 1'b1;
                end
            end
            default:
                gen_state <= G_IDLE;
        endcase
    end
end

// sticky interrupt status, set wins over clear
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        irq_status <= {`IRQ_WIDTH{1'b0}};
    else
    begin
        if (write_done && aligned && idx == `IDX_IRQ_CLEAR)
            irq_status <= irq_status & ~pwdata[`IRQ_WIDTH-1:0]
                | {(|wide_sat) | (|narrow_sat), burst_end};
        else
            irq_status <= irq_status
                | {(|wide_sat) | (|narrow_sat), burst_end};
    end
end

assign irq = |(irq_status & irq_enable);

endmodule // phy_frame_selftest_counters

`default_nettype wire

// ### sim/selftest_chk.sv
`timescale 1ns/1ps
`default_nettype none

module selftest_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // generator and enables
    input wire logic gen_frame_req,
    input wire logic gen_frame_sent,
    input wire logic gen_busy,
    input wire logic [15:0] gen_frame_length,
    input wire logic checker_enable,
    input wire logic gen_enable,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // bus answers after exactly one wait state, for one cycle
    pready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    pready_one_a: assert property (pready |=> !pready)
        else $error("pready held");
    // settings and enables leave reset at their defaults
    reset_vals_a: assert property ($rose(presetn) |->
        gen_frame_length == 16'h0040 && !checker_enable && !gen_enable && !irq)
        else $error("bad reset values");
    // generator request handshake
    req_pulse_a: assert property (gen_frame_req |=> !gen_frame_req)
        else $error("request longer than one cycle");
    req_busy_a: assert property (gen_frame_req |-> gen_busy)
        else $error("request while not busy");
    req_cause_a: assert property (gen_frame_req |-> $past(gen_enable))
        else $error("request without enable");
    busy_hold_a: assert property (gen_busy && !gen_frame_sent |=> gen_busy)
        else $error("busy dropped early");
    resend_a: assert property (gen_busy && gen_frame_sent
        |=> gen_frame_req == gen_busy)
        else $error("no follow-up after sent");

    // main scenarios reached
    cover property (pready && pslverr);
    cover property (gen_frame_req);
    cover property (irq);
endmodule // selftest_chk

bind phy_frame_selftest_counters selftest_chk chk_u (.pclk, .presetn,
    .psel, .penable, .pready, .pslverr, .gen_frame_req, .gen_frame_sent,
    .gen_busy, .gen_frame_length, .checker_enable, .gen_enable, .irq);

`default_nettype wire

// ### sim/gen_model.sv
`timescale 1ns/1ps
`default_nettype none

module gen_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // generator handshake
    input wire logic gen_frame_req,
    input wire logic [3:0] lat,
    output var logic gen_frame_sent
);
    logic [4:0] cnt;

    // one sent pulse per request, lat+2 cycles later
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 5'h00;
            gen_frame_sent <= 1'b0;
        end
        else
        begin
            gen_frame_sent <= (cnt == 5'h01);
            if (gen_frame_req)
                cnt <= {1'b0, lat} + 5'h01;
            else if (cnt != 5'h00)
                cnt <= cnt - 5'h01;
        end
    end
endmodule // gen_model

`default_nettype wire

// ### sim/phy_frame_selftest_counters_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "selftest_consts.vh"

module phy_frame_selftest_counters_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata;
    logic rx_frame_done, rx_crc_ok, rx_sfd_missing, tx_frame_done, tx_crc_ok;
    logic [15:0] rx_frame_len, tx_frame_len, gen_frame_length, v;
    logic gen_frame_req, gen_frame_sent, gen_busy, checker_enable;
    logic gen_enable, irq;
    logic [3:0] lat;
    logic [32:0] expq[$];
    logic [15:0] seed = 16'd43960;
    logic [15:0] cexp [14] = '{0, 3, 0, 1, 0, 1, 1, 1, 2, 1, 0, 1, 0, 1};
    int n_mismatch, comparisons, n_req, n;

    phy_frame_selftest_counters dut_u (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_frame_done,
        .rx_frame_len, .rx_crc_ok, .rx_sfd_missing, .tx_frame_done,
        .tx_frame_len, .tx_crc_ok, .gen_frame_req, .gen_frame_length,
        .gen_frame_sent, .gen_busy, .checker_enable, .gen_enable, .irq);
    gen_model gen_u (.pclk, .presetn, .gen_frame_req, .lat, .gen_frame_sent);

    function logic [15:0] xorshift();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed;
    endfunction

    task chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
        comparisons++;
        if (seen !== ex)
        begin
            n_mismatch++;
            $display("MISMATCH %0s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task give_up(input logic hit);
        if (hit)
        begin
            n_mismatch++;
            tally_and_finish;
        end
    endtask

    // one apb transfer; reads note the expected answer first
    task apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
             input logic [32:0] x);
        if (!w)
            expq.push_back(x);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        give_up(pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [15:0] idx, input logic [15:0] ex);
        apb(1'b0, idx, 32'h0, {17'h0, ex});
    endtask

    task wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d, 33'h0);
    endtask

    // one checker result pulse on the rx or the tx side
    task frm(input logic rx, input logic [15:0] len, input logic ok,
             input logic sfd);
        @(posedge pclk);
        rx_frame_done <= rx;
        tx_frame_done <= !rx;
        rx_frame_len <= len;
        tx_frame_len <= len;
        rx_crc_ok <= ok;
        tx_crc_ok <= ok;
        rx_sfd_missing <= sfd;
        @(posedge pclk);
        rx_frame_done <= 1'b0;
        tx_frame_done <= 1'b0;
    endtask

    // read all counters, upper half before lower
    task rd_counters(input logic use_tab);
        for (int i = 0; i < 14; i++)
            rd(16'h40a3 + i[15:0], use_tab ? cexp[i] : 16'h0);
    endtask

    // clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // compare finished reads with the oldest noted expectation
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk("read", {pslverr, pslverr ? 32'h0 : prdata}, expq.pop_front());
        if (gen_frame_req === 1'b1)
            n_req++;
    end

    // main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, rx_frame_done, tx_frame_done} = 0;
        {rx_crc_ok, tx_crc_ok, rx_sfd_missing, paddr, pwdata} = 0;
        {rx_frame_len, tx_frame_len} = 0;
        lat = 4'h1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(`IDX_GEN_LENGTH, 16'h0040);
        rd(`IDX_GEN_BURST, 16'h0000);
        apb(1'b0, 16'h40bf, 32'h0, {1'b1, 32'h0});
        wr(`IDX_RX_GOOD_LO, 32'hffff);
        frm(1'b1, 16'd100, 1'b1, 1'b0);
        rd_counters(1'b0);
        wr(`IDX_CONTROL, 32'h8000);
        frm(1'b1, 16'd64, 1'b1, 1'b0);
        frm(1'b1, 16'd1518, 1'b1, 1'b0);
        frm(1'b1, 16'd1519, 1'b1, 1'b0);
        frm(1'b1, 16'd63, 1'b1, 1'b0);
        frm(1'b1, 16'd100, 1'b0, 1'b0);
        frm(1'b1, 16'd2000, 1'b0, 1'b0);
        frm(1'b1, 16'd10, 1'b0, 1'b0);
        frm(1'b1, 16'd100, 1'b1, 1'b1);
        frm(1'b0, 16'd64, 1'b1, 1'b0);
        frm(1'b0, 16'd1600, 1'b1, 1'b0);
        frm(1'b0, 16'd50, 1'b1, 1'b0);
        frm(1'b0, 16'd100, 1'b0, 1'b0);
        rd_counters(1'b1);
        rd_counters(1'b0);
        frm(1'b1, 16'd80, 1'b1, 1'b0);
        frm(1'b1, 16'd90, 1'b1, 1'b0);
        rd(`IDX_RX_GOOD_HI, 16'h0);
        frm(1'b1, 16'd90, 1'b1, 1'b0);
        rd(`IDX_RX_GOOD_LO, 16'h2);
        // increment in the clearing read's access cycle is kept
        fork
            rd(`IDX_RX_CRC_ERR, 16'h0);
            begin
                @(posedge pclk);
                frm(1'b1, 16'd100, 1'b0, 1'b0);
            end
        join
        rd(`IDX_RX_CRC_ERR, 16'h1);
        v = xorshift();
        wr(`IDX_GEN_LENGTH, {16'h0, v});
        rd(`IDX_GEN_LENGTH, v);
        chk("length", {17'h0, gen_frame_length}, {17'h0, v});
        // finite burst ends by itself
        v = xorshift();
        lat <= v[2:0] + 4'h1;
        wr(`IDX_GEN_BURST, 32'h2);
        n_req = 0;
        wr(`IDX_CONTROL, 32'h9000);
        @(posedge pclk);
        for (n = 0; n < 300 && gen_enable !== 1'b0; n++)
            @(posedge pclk);
        give_up(n == 300);
        chk("requests", {1'b0, n_req}, 33'h2);
        rd(`IDX_CONTROL, 16'h8000);
        chk("irq masked", {32'h0, irq}, 33'h0);
        wr(`IDX_IRQ_ENABLE, 32'h1);
        @(posedge pclk);
        chk("irq on", {32'h0, irq}, 33'h1);
        wr(`IDX_IRQ_CLEAR, 32'h1);
        @(posedge pclk);
        chk("irq off", {32'h0, irq}, 33'h0);
        // burst zero runs until software stops it
        wr(`IDX_GEN_BURST, 32'h0);
        n_req = 0;
        wr(`IDX_CONTROL, 32'h9000);
        repeat (80) @(posedge pclk);
        chk("running", {32'h0, gen_enable}, 33'h1);
        chk("frames", {32'h0, n_req > 3}, 33'h1);
        wr(`IDX_CONTROL, 32'h8000);
        for (n = 0; n < 40 && gen_busy !== 1'b0; n++)
            @(posedge pclk);
        give_up(n == 40);
        tally_and_finish;
    end
endmodule // phy_frame_selftest_counters_bench

`default_nettype wire
